// [bench/bbpll_props.sv]
// Purpose: Concurrent checks on the register block ports
// Assumes: One mclk domain, rst_n asynchronous active low
// Notes:   Bound to the top module at the foot of this file
module bbpll_props
    import bbpll_pkg::*;
#(
    parameter longint SETTLE_CYC = DET_SETTLE_CYC
) (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        wr_stb,
    input wire logic [6:0]  wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic [6:0]  rd_addr,
    input wire logic [3:0]  rd_bit,
    input wire logic        init_stb,
    input wire logic        init_cw,
    input wire logic        lock_det_on,
    input wire logic        hit_pulse,
    input wire logic [15:0] rd_data,
    input wire logic        spi_so,
    input wire logic [15:0] out_word,
    input wire logic        chopping_clock_on,
    input wire logic        chopping_clock,
    input wire logic        detector_digital_on,
    input wire logic        hit_count_en,
    input wire logic [15:0] hit_count,
    input wire logic [14:0] loop_cfg,
    input wire logic        loop_on
);
    timeunit 1ns;
    timeprecision 1ps;
    // ============================================================
    // Assertions
    // ============================================================
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_bb_write_taken: assert property (wr_stb && wr_addr == ADDR_BASEBAND && !init_stb
        |=> out_word == ($past(wr_data) & BB_WRITE_MASK))
        else $error("baseband write lost");
    a_init_pulsed: assert property (init_stb && !init_cw |=> out_word == BB_INIT_PULSED)
        else $error("pulsed init wrong");
    a_init_cw_load: assert property (init_stb && init_cw |=> out_word == BB_INIT_CW && loop_cfg == LC_INIT[14:0])
        else $error("cw init wrong");
    a_chop_stopped: assert property (!chopping_clock_on [*3] |-> !chopping_clock)
        else $error("chop runs while off");
    a_chop_runs: assert property ((chopping_clock_on && $stable(chopping_clock)) [*8] ##1
                                  (chopping_clock_on && $stable(chopping_clock)) [*2] |-> 1'b0)
        else $error("chop stuck while on");
    a_loop_held: assert property (loop_on && !init_stb |=> $stable(loop_cfg))
        else $error("loop word moved while on");
    a_loop_write: assert property (wr_stb && wr_addr == ADDR_LOOPCFG && !loop_on && !init_stb
                                   |=> loop_cfg == $past(wr_data[14:0]))
        else $error("loop write not taken");
    a_unused_zero: assert property (rd_addr == ADDR_BASEBAND |=> (rd_data & ~BB_WRITE_MASK) == 16'h0000)
        else $error("unused bits nonzero");
    a_raw_lock_one: assert property ((loop_cfg[14:13] == TMUX_LOCK && !lock_det_on) [*6] |-> spi_so)
        else $error("test lock not one");
    a_func_serial: assert property ((loop_cfg[14:13] == TMUX_FUNC && !wr_stb && !init_stb
                                     && $stable(rd_addr) && $stable(rd_bit)) [*3] |-> spi_so == rd_data[rd_bit])
        else $error("serial bit wrong");
    a_count_gated: assert property (!detector_digital_on [*2] |-> !hit_count_en ##1 $stable(hit_count))
        else $error("hits while off");
    c_init_cw: cover property (init_stb && init_cw);
    c_lock_out: cover property (loop_cfg[14:13] == TMUX_LOCK && spi_so);
    c_hit: cover property (hit_count_en && hit_pulse);
endmodule // bbpll_props
bind radar_baseband_pll_cfg_regs bbpll_props #(.SETTLE_CYC(SETTLE_CYC)) u_props (
    .mclk, .rst_n, .wr_stb, .wr_addr, .wr_data, .rd_addr, .rd_bit, .init_stb, .init_cw, .lock_det_on, .hit_pulse,
    .rd_data, .spi_so, .chopping_clock_on, .chopping_clock,
    .out_word({3'h0, div_bias_on, 3'h0, quad_sense_on, detector_digital_on, 1'b0, hold_boost_off,
               chopping_clock_on, 1'b0, startup_boost, baseband_amp_on, sampling_switch_on}),
    .detector_digital_on, .hit_count_en, .hit_count, .loop_cfg, .loop_on);

// [bench/host_model.sv]
// Purpose: Host side model driving register writes, reads and init pulses
// Assumes: Requests change at the falling edge of mclk and are held over one rising edge
// Notes:   Loop word writes are refused while the loop is on, unless a scenario forces one
module host_model
    import bbpll_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        loop_on,
    input  wire logic [15:0] rd_data,
    output logic             wr_stb,
    output logic [6:0]       wr_addr,
    output logic [15:0]      wr_data,
    output logic [6:0]       rd_addr,
    output logic [3:0]       rd_bit,
    output logic             init_stb,
    output logic             init_cw
);
    timeunit 1ns;
    timeprecision 1ps;
    // ============================================================
    // Idle levels and request tasks
    // ============================================================
    initial begin
        {wr_stb, wr_addr, wr_data, rd_addr, rd_bit, init_stb, init_cw} = '0;
    end
    // One word write; data shows its inverse once released
    task automatic write(input logic [6:0] a, input logic [15:0] d, input bit force_it = 1'b0);
        if (a == ADDR_LOOPCFG && loop_on && !force_it) return;
        @(negedge mclk);
        wr_stb = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(negedge mclk);
        wr_stb = 1'b0;
        wr_data = ~d;
    endtask
    // Parallel read word one cycle after the address
    task automatic read(input logic [6:0] a, output logic [15:0] d);
        @(negedge mclk);
        rd_addr = a;
        @(negedge mclk);
        d = rd_data;
    endtask
    // Init sequence load pulse
    task automatic init(input logic cw);
        @(negedge mclk);
        init_stb = 1'b1;
        init_cw = cw;
        @(negedge mclk);
        init_stb = 1'b0;
    endtask
endmodule // host_model

// [bench/testbench.sv]
// Purpose: Self-checking bench for the baseband and loop configuration registers
// Assumes: Inputs driven at the falling edge, mclk 8 ns
// Notes:   Detector settle shortened to 20 cycles
module testbench
    import bbpll_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SETTLE = 20;
    logic mclk, rst_n, wr_stb, init_stb, init_cw, lock_pin, lock_det_on, ref_clk_pin, div_clk_pin, hit_pulse;
    logic spi_so, chop_on, chop_clk, hit_count_en, loop_on;
    logic [6:0]  wr_addr, rd_addr;
    logic [3:0]  rd_bit;
    logic [15:0] wr_data, rd_data, hit_count, d;
    wire  [15:0] out_word;
    logic [14:0] loop_cfg;
    logic [15:0] bb_m, lc_m;                      // Reference model of both words
    int          n_mismatch, n_tests, seed, toggles, cyc;
    // ============================================================
    // Clock, pin stimulus and instances
    // ============================================================
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // Reference toggles every 2 cycles, divider every 4
    initial begin
        cyc = 0;
        forever begin
            ref_clk_pin = cyc[1];
            div_clk_pin = cyc[2];
            @(negedge mclk);
            cyc++;
        end
    end
    host_model host (.mclk, .loop_on, .rd_data, .wr_stb, .wr_addr, .wr_data, .rd_addr, .rd_bit, .init_stb, .init_cw);
    radar_baseband_pll_cfg_regs #(.SETTLE_CYC(SETTLE)) uut (.mclk, .rst_n, .wr_stb, .wr_addr, .wr_data, .rd_addr,
        .rd_bit, .init_stb, .init_cw, .lock_pin, .lock_det_on, .ref_clk_pin, .div_clk_pin, .hit_pulse, .rd_data,
        .spi_so, .div_bias_on(out_word[12]), .quad_sense_on(out_word[8]), .detector_digital_on(out_word[7]),
        .hold_boost_off(out_word[5]), .chopping_clock_on(chop_on), .chopping_clock(chop_clk),
        .startup_boost(out_word[2]), .baseband_amp_on(out_word[1]), .sampling_switch_on(out_word[0]),
        .hit_count_en, .hit_count, .loop_cfg, .loop_on);
    assign out_word[4] = chop_on;
    assign {out_word[15:13], out_word[11:9], out_word[6], out_word[3]} = '0;
    // ============================================================
    // Shared tasks
    // ============================================================
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp, input string what);
        host.read(a, d);
        check(d, exp, what);
    endtask
    task automatic hits(input int n);
        repeat (n) begin
            @(negedge mclk) hit_pulse = 1'b1;
            @(negedge mclk) hit_pulse = 1'b0;
        end
    endtask
    // Counts output changes over 64 cycles
    task automatic count_toggles(input bit use_so);
        logic last;
        toggles = 0;
        last = use_so ? spi_so : chop_clk;
        repeat (64) begin
            @(negedge mclk);
            if ((use_so ? spi_so : chop_clk) !== last) toggles++;
            last = use_so ? spi_so : chop_clk;
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Watchdog against a hung run
    initial begin
        #300000;
        n_mismatch++;
        $display("wrong value at %0t: run timed out", $time);
        give_verdict();
    end
    // ============================================================
    // Main sequence
    // ============================================================
    initial begin
        {rst_n, lock_pin, lock_det_on, hit_pulse, n_mismatch, n_tests} = '0;
        seed = 32'hef6f;
        repeat (10) @(negedge mclk);
        rst_n = 1'b1;
        rd_chk(ADDR_BASEBAND, 16'h0000, "baseband reset");
        rd_chk(ADDR_LOOPCFG, 16'h0000, "loop reset");
        host.write(ADDR_BASEBAND, 16'h0100);
        repeat (QS_SETTLE_CYC) @(negedge mclk);
        check(out_word, 16'h0100, "quad sense on");
        $display("test reset values done");
        host.write(ADDR_BASEBAND, 16'h0080);
        hits(3);
        repeat (SETTLE) @(negedge mclk);
        hits(5);
        check(hit_count, 16'd5, "hits after settle");
        host.write(ADDR_BASEBAND, 16'h0000);
        hits(2);
        check(hit_count, 16'd5, "hits while off");
        $display("test detector settle done");
        host.init(1'b0);
        check(out_word, 16'h0092, "pulsed init outputs");
        host.init(1'b1);
        rd_chk(ADDR_BASEBAND, 16'h10b3, "cw init word");
        rd_chk(ADDR_LOOPCFG, 16'h053a, "loop init word");
        $display("test init values done");
        for (int i = 0; i < 12; i++) begin
            d = 16'($random(seed));
            host.write(ADDR_BASEBAND, d);
            bb_m = d & 16'h11b7;
            check(out_word, bb_m, "baseband outputs");
            rd_chk(ADDR_BASEBAND, bb_m, "baseband readback");
            d = 16'($random(seed));
            host.write(ADDR_LOOPCFG, d & 16'h9fff);
            lc_m = d & 16'h1fff;
            rd_chk(ADDR_LOOPCFG, lc_m, "loop readback");
            host.write(7'h7f, d);
            check(out_word, bb_m, "unmapped write");
        end
        for (int b = 0; b < 16; b++) begin
            host.rd_addr = ADDR_BASEBAND;
            host.rd_bit = b[3:0];
            repeat (3) @(negedge mclk);
            check(16'(spi_so), 16'(bb_m[b]), "serial bit");
        end
        $display("test random words done");
        host.write(ADDR_DIRECT, 16'h0100);
        host.write(ADDR_LOOPCFG, 16'h0000, 1'b1);
        check({1'b0, loop_cfg}, lc_m, "loop held");
        host.write(ADDR_DIRECT, 16'h0000);
        host.write(ADDR_LOOPCFG, {1'b0, TMUX_LOCK, 13'h0});
        for (int k = 0; k < 3; k++) begin
            repeat (8) @(negedge mclk);
            check(16'(spi_so), 16'(k != 1), "test lock out");
            {lock_pin, lock_det_on} = {k[0], 1'b1};
        end
        host.write(ADDR_BASEBAND, 16'h0012);
        check(out_word, 16'h0012, "write in test mode");
        for (int m = 2; m < 4; m++) begin
            host.write(ADDR_LOOPCFG, {1'b0, m[1:0], 13'h0});
            repeat (16) @(negedge mclk);
            count_toggles(1'b1);
            check(16'(toggles), (m == 2) ? 16'd8 : 16'd4, "divided clock out");
        end
        host.write(ADDR_LOOPCFG, 16'h0000);
        $display("test loop and test output done");
        repeat (10) @(negedge mclk);
        count_toggles(1'b0);
        check(16'(toggles), 16'(64 / CHOP_HALF_CYC), "chop toggles");
        host.write(ADDR_BASEBAND, 16'h0000);
        repeat (3) @(negedge mclk);
        check(16'(chop_clk), 16'h0000, "chop stopped");
        $display("test chopping clock done");
        give_verdict();
    end
endmodule // testbench

// [rtl/bbpll_cfg_if.sv]
// Purpose: Carries the loop configuration fields into the test output selector
// Assumes: Single mclk domain
// Notes:   Used only between the top module and its test selector
interface bbpll_cfg_if;
    logic [1:0] tmux;       // Test multiplexer field
    logic       lock_raw;   // Raw lock after the pin synchroniser, one if detection off
    logic       ref_clk;    // Reference clock sample
    logic       div_clk;    // Divider clock sample
    logic       reg_so;     // Normal serial read bit
    logic       so;         // Selected serial output
    modport top (output tmux, lock_raw, ref_clk, div_clk, reg_so, input so);
    modport sel (input tmux, lock_raw, ref_clk, div_clk, reg_so, output so);
endinterface

// [rtl/bbpll_pkg.sv]
// Purpose: Shared constants for the baseband control and first loop configuration registers
// Assumes: 16-bit register words written over a serial peripheral port by the host
// Notes:   Register addresses are not printed, so they are plain localparams here
package bbpll_pkg;
    // ============================================================
    // Register addressing
    // ============================================================
    localparam logic [6:0]  ADDR_BASEBAND   = 7'h01;   // Baseband control word
    localparam logic [6:0]  ADDR_LOOPCFG    = 7'h04;   // First loop configuration word
    localparam logic [6:0]  ADDR_DIRECT     = 7'h00;   // Direct-access word (loop enable)
    // ============================================================
    // Reset and init values
    // ============================================================
    localparam logic [15:0] BB_RESET        = 16'h0000;
    localparam logic [15:0] BB_INIT_PULSED  = 16'h0092;
    localparam logic [15:0] BB_INIT_CW      = 16'h10b3;
    localparam logic [15:0] BB_WRITE_MASK   = 16'h11b7; // Implemented bits only
    localparam logic [15:0] LC_RESET        = 16'h0000;
    localparam logic [15:0] LC_INIT         = 16'h053a;
    localparam logic [15:0] LC_WRITE_MASK   = 16'h7fff; // b15 unused
    // ============================================================
    // Field positions
    // ============================================================
    localparam int BIT_DIV_BIAS    = 12;
    localparam int BIT_QUAD_SENSE  = 8;
    localparam int BIT_DET_DIG     = 7;
    localparam int BIT_HOLD_BOOST  = 5;
    localparam int BIT_CHOP        = 4;
    localparam int BIT_STARTUP     = 2;
    localparam int BIT_AMP         = 1;
    localparam int BIT_SAMPLE      = 0;
    localparam int BIT_LOOP_EN     = 8;
    localparam int TMUX_HI         = 14;
    localparam int TMUX_LO         = 13;
    // ============================================================
    // Test multiplexer codes
    // ============================================================
    localparam logic [1:0] TMUX_FUNC = 2'h0;
    localparam logic [1:0] TMUX_LOCK = 2'h1;
    localparam logic [1:0] TMUX_REF4 = 2'h2;
    localparam logic [1:0] TMUX_DIV4 = 2'h3;
    // ============================================================
    // Timing
    // ============================================================
    localparam int  CLK_MHZ        = 125;
    localparam int  DET_SETTLE_MS  = 50;
    localparam longint DET_SETTLE_CYC = longint'(DET_SETTLE_MS) * 1000 * 1000 * CLK_MHZ / 1000;
    localparam int  CHOP_HALF_CYC  = 8;            // Chopping clock half period in cycles
    localparam int  QS_SETTLE_US   = 200;
    localparam int  QS_SETTLE_CYC  = QS_SETTLE_US * CLK_MHZ;
endpackage

// [rtl/radar_baseband_pll_cfg_regs.sv]
// Purpose: Baseband control and first loop configuration registers with their outputs
// Assumes: Host writes come as decoded word strobes from the serial port logic
// Notes:   Pin inputs are synchronised through three flip-flops
//
// How it works
// - baseband word resets zero, init loads mode value
// - detector counts hits 50 ms after first enable
// - bit 5 high turns hold boost off
// - bit 4 runs or stops chopping clock
// - bit 2 startup boost, bit 1 amplifier
// - bit 0 closes sampling switch
// - loop word resets zero, init loads 0x053A
// - test field selects serial output source
// - writes still work in test mode
// - test lock is raw, one if disabled
// - loop configuration writes ignored while loop enabled, init still loads it
module radar_baseband_pll_cfg_regs
    import bbpll_pkg::*;
#(
    parameter longint SETTLE_CYC = DET_SETTLE_CYC   // Detector settle count
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        wr_stb,              // One-cycle write strobe
    input  wire logic [6:0]  wr_addr,             // Write address
    input  wire logic [15:0] wr_data,             // Write data
    input  wire logic [6:0]  rd_addr,             // Read address
    input  wire logic [3:0]  rd_bit,              // Bit index being shifted out
    input  wire logic        init_stb,            // Init sequence load pulse
    input  wire logic        init_cw,             // Init mode: 1 continuous wave
    input  wire logic        lock_pin,            // Raw internal lock
    input  wire logic        lock_det_on,         // Lock detection enabled
    input  wire logic        ref_clk_pin,         // Reference clock
    input  wire logic        div_clk_pin,         // Divider clock
    input  wire logic        hit_pulse,           // Detector hit event
    output logic [15:0]      rd_data,             // Parallel read word
    output logic             spi_so,              // Serial data output
    output logic             div_bias_on,
    output logic             quad_sense_on,
    output logic             detector_digital_on,
    output logic             hold_boost_off,
    output logic             chopping_clock_on,
    output logic             chopping_clock,      // Running chop clock
    output logic             startup_boost,
    output logic             baseband_amp_on,
    output logic             sampling_switch_on,
    output logic             hit_count_en,        // Detector allowed to count
    output logic [15:0]      hit_count,           // Counted hits
    output logic [14:0]      loop_cfg,            // Loop configuration fields
    output logic             loop_on              // Loop enable from direct word
);
    bbpll_cfg_if cfg ();

    logic [15:0] bb_reg;          // Baseband control
    logic [15:0] lc_reg;          // Loop configuration one
    logic        loop_en_reg;     // Copy of direct-access loop enable
    logic [2:0]  lock_s_reg;      // Lock synchroniser
    logic [2:0]  ref_s_reg;       // Reference synchroniser
    logic [2:0]  div_s_reg;       // Divider synchroniser
    logic        lock_q_reg;      // Accepted lock level
    logic        ref_q_reg;       // Accepted reference level
    logic        div_q_reg;       // Accepted divider level
    logic        det_seen_reg;    // Detector enabled once since reset
    logic        det_ready_reg;   // Settle time elapsed
    logic [31:0] settle_cnt_reg;  // Settle counter
    logic [3:0]  chop_cnt_reg;    // Chop half period counter
    logic        chop_reg;        // Chop clock level
    logic [15:0] hits_reg;        // Hit counter
    logic [15:0] rd_reg;          // Read word register

    // ============================================================
    // Baseband control register
    // ============================================================
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bb_reg <= BB_RESET;
        end else if (init_stb) begin
            bb_reg <= init_cw ? BB_INIT_CW : BB_INIT_PULSED;
        end else if (wr_stb && wr_addr == ADDR_BASEBAND) begin
            bb_reg <= wr_data & BB_WRITE_MASK;
        end
    end

    // ============================================================
    // Direct-access loop enable copy
    // ============================================================
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            loop_en_reg <= 1'b0;
        end else if (init_stb) begin
            loop_en_reg <= 1'b0;
        end else if (wr_stb && wr_addr == ADDR_DIRECT) begin
            loop_en_reg <= wr_data[BIT_LOOP_EN];
        end
    end

    // ============================================================
    // Loop configuration register, writes ignored while loop enabled, init still loads it
    // ============================================================
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lc_reg <= LC_RESET;
        end else if (init_stb) begin
            lc_reg <= LC_INIT;
        end else if (wr_stb && wr_addr == ADDR_LOOPCFG && !loop_en_reg) begin
            lc_reg <= wr_data & LC_WRITE_MASK;
        end
    end

    // ============================================================
    // Pin synchronisers, accept when second and third agree
    // ============================================================
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lock_s_reg <= 3'h0;
            ref_s_reg  <= 3'h0;
            div_s_reg  <= 3'h0;
            lock_q_reg <= 1'b0;
            ref_q_reg  <= 1'b0;
            div_q_reg  <= 1'b0;
        end else begin
            lock_s_reg <= {lock_s_reg[1:0], lock_pin};
            ref_s_reg  <= {ref_s_reg[1:0], ref_clk_pin};
            div_s_reg  <= {div_s_reg[1:0], div_clk_pin};
            if (lock_s_reg[1] == lock_s_reg[2]) begin
                lock_q_reg <= lock_s_reg[2];
            end
            if (ref_s_reg[1] == ref_s_reg[2]) begin
                ref_q_reg <= ref_s_reg[2];
            end
            if (div_s_reg[1] == div_s_reg[2]) begin
                div_q_reg <= div_s_reg[2];
            end
        end
    end

    // ============================================================
    // Detector settle: 50 ms after first enable
    // ============================================================
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            det_seen_reg   <= 1'b0;
            det_ready_reg  <= 1'b0;
            settle_cnt_reg <= 32'h0;
        end else if (!det_ready_reg) begin
            if (bb_reg[BIT_DET_DIG]) begin
                det_seen_reg <= 1'b1;
            end
            if (det_seen_reg || bb_reg[BIT_DET_DIG]) begin
                if (settle_cnt_reg == 32'(SETTLE_CYC - 1)) begin
                    det_ready_reg <= 1'b1;
                end else begin
                    settle_cnt_reg <= settle_cnt_reg + 32'h1;
                end
            end
        end
    end

    // ============================================================
    // Hit counter, only once settled and enabled
    // ============================================================
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hits_reg <= 16'h0;
        end else if (hit_count_en && hit_pulse) begin
            hits_reg <= hits_reg + 16'h1;
        end
    end

    // ============================================================
    // Chopping clock generator
    // ============================================================
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            chop_cnt_reg <= 4'h0;
            chop_reg     <= 1'b0;
        end else if (!bb_reg[BIT_CHOP]) begin
            chop_cnt_reg <= 4'h0;
            chop_reg     <= 1'b0;
        end else if (chop_cnt_reg == 4'(CHOP_HALF_CYC - 1)) begin
            chop_cnt_reg <= 4'h0;
            chop_reg     <= ~chop_reg;
        end else begin
            chop_cnt_reg <= chop_cnt_reg + 4'h1;
        end
    end

    // ============================================================
    // Read word and serial bit
    // ============================================================
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_reg <= 16'h0;
        end else if (rd_addr == ADDR_BASEBAND) begin
            rd_reg <= bb_reg & BB_WRITE_MASK;
        end else if (rd_addr == ADDR_LOOPCFG) begin
            rd_reg <= lc_reg & LC_WRITE_MASK;
        end else begin
            rd_reg <= 16'h0;
        end
    end

    // ============================================================
    // Test selector hookup
    // ============================================================
    assign cfg.tmux     = lc_reg[TMUX_HI:TMUX_LO];
    assign cfg.lock_raw = lock_det_on ? lock_q_reg : 1'b1;
    assign cfg.ref_clk  = ref_q_reg;
    assign cfg.div_clk  = div_q_reg;
    assign cfg.reg_so   = rd_reg[rd_bit];

    test_out_sel u_sel (
        .mclk  (mclk),
        .rst_n (rst_n),
        .cfg   (cfg)
    );

    // ============================================================
    // Outputs
    // ============================================================
    assign rd_data             = rd_reg;
    assign spi_so              = cfg.so;
    assign div_bias_on         = bb_reg[BIT_DIV_BIAS];
    assign quad_sense_on       = bb_reg[BIT_QUAD_SENSE];
    assign detector_digital_on = bb_reg[BIT_DET_DIG];
    assign hold_boost_off      = bb_reg[BIT_HOLD_BOOST];
    assign chopping_clock_on   = bb_reg[BIT_CHOP];
    assign chopping_clock      = chop_reg;
    assign startup_boost       = bb_reg[BIT_STARTUP];
    assign baseband_amp_on     = bb_reg[BIT_AMP];
    assign sampling_switch_on  = bb_reg[BIT_SAMPLE];
    assign hit_count_en        = det_ready_reg && bb_reg[BIT_DET_DIG];
    assign hit_count           = hits_reg;
    assign loop_cfg            = lc_reg[14:0];
    assign loop_on             = loop_en_reg;
endmodule // radar_baseband_pll_cfg_regs

// [rtl/test_out_sel.sv]
// Purpose: Chooses the serial data output: register data or loop test signals
// Assumes: Reference and divider clock samples are already synchronised
// Notes:   Divide-by-4 is taken from rising edges of each sampled clock
module test_out_sel
    import bbpll_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst_n,
    bbpll_cfg_if.sel  cfg
);
    logic [1:0] ref_cnt_reg;   // Reference edge count
    logic [1:0] div_cnt_reg;   // Divider edge count
    logic       ref_d_reg;     // Previous reference sample
    logic       div_d_reg;     // Previous divider sample
    logic       so_reg;        // Registered output

    // ============================================================
    // Divide-by-4 counters on rising edges
    // ============================================================
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ref_cnt_reg <= 2'h0;
            div_cnt_reg <= 2'h0;
            ref_d_reg   <= 1'b0;
            div_d_reg   <= 1'b0;
        end else begin
            ref_d_reg <= cfg.ref_clk;
            div_d_reg <= cfg.div_clk;
            if (cfg.ref_clk && !ref_d_reg) begin
                ref_cnt_reg <= ref_cnt_reg + 2'h1;
            end
            if (cfg.div_clk && !div_d_reg) begin
                div_cnt_reg <= div_cnt_reg + 2'h1;
            end
        end
    end

    // ============================================================
    // Output selector
    // ============================================================
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            so_reg <= 1'b0;
        end else begin
            case (cfg.tmux)
                TMUX_LOCK: so_reg <= cfg.lock_raw;
                TMUX_REF4: so_reg <= ref_cnt_reg[1];
                TMUX_DIV4: so_reg <= div_cnt_reg[1];
                default:   so_reg <= cfg.reg_so;
            endcase
        end
    end

    assign cfg.so = so_reg;
endmodule // test_out_sel
